/* File: dv/pld_edge_src.sv */
// Phase-detector edge source feeding the lock detector
module pld_edge_src (
   input wire logic clk,
   output logic ref_o,
   output logic fb_o
);
   timeunit 1ns;
   timeprecision 100ps;

   initial
   begin
      ref_o = 1'b0;
      fb_o = 1'b0;
   end

   task automatic send(input int d);
      int t0;
      int t1;
      t0 = d < 0 ? -d : 0;
      t1 = d < 0 ? 0 : d;
      for (int i = 0; i < t0 + t1 + 4; i++)
      begin
         @(posedge clk);
         ref_o <= i >= t0 && i < t0 + 3;
         fb_o <= i >= t1 && i < t1 + 3;
      end
   endtask
endmodule // pld_edge_src

/* File: dv/testbench.sv */
// Self-checking bench for the lock detector
`include "pld_params.svh"
module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam logic [11:0] CTRL_A = 12'(`PLD_CTRL_IDX << `PLD_IDX_LSB);
   localparam logic [11:0] STAT_A = 12'(`PLD_STAT_IDX << `PLD_IDX_LSB);
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic ref_in;
   logic fb_in;
   logic lock_flag;
   logic [31:0] rd;
   logic er;
   int num_errors = 0;
   int num_checks = 0;
   int cnt = 0, lk = 0, sel = 0, rng = 0, dis = 0;
   int hy[8] = '{3, 3, 3, 3, 3, 6, -8, 9};
   int lo[8] = '{1, 1, 1, 1, -1, 3, 4, 5};

   always #12.5 clk = ~clk;

   pld_top i_dut (.CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .REF_IN(ref_in), .FB_IN(fb_in), .LOCK_FLAG(lock_flag));
   pld_edge_src i_src (.clk(clk), .ref_o(ref_in), .fb_o(fb_in));

   task automatic end_of_test();
      if (num_errors == 0 && num_checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask

   task automatic apb(input bit w, input logic [11:0] a, input logic [31:0] wd);
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do
         @(posedge clk);
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   function automatic int need_of(input int s);
      return s == 0 ? `PLD_NEED_00 : s == 1 ? `PLD_NEED_01 : s == 2 ? `PLD_NEED_10 : `PLD_NEED_11;
   endfunction

   task automatic stat();
      apb(0, STAT_A, 32'h0);
      chk("status", {16'h0, 8'(cnt), 7'h0, 1'(lk)}, rd);
      chk("lock_pin", 32'(lk), {31'h0, lock_flag});
      chk("stat_err", 32'h0, {31'h0, er});
   endtask

   task automatic cfg(input int s, input int r, input int d);
      apb(1, CTRL_A, 32'h1);
      cnt = 0;
      lk = 0;
      dis = 1;
      stat();
      apb(1, CTRL_A, 32'(s * 4 + r * 2 + d));
      apb(0, CTRL_A, 32'h0);
      chk("ctrl", 32'(s * 4 + r * 2 + d), rd);
      sel = s;
      rng = r;
      dis = d;
   endtask

   task automatic pair(input int d);
      int a;
      a = d < 0 ? -d : d;
      i_src.send(d);
      repeat (16) @(posedge clk);
      if (dis != 0)
         cnt = 0;
      else if (a < (rng ? `PLD_WIN_LO_CYC : `PLD_WIN_HI_CYC))
      begin
         if (cnt < need_of(sel))
            cnt++;
         if (cnt == need_of(sel))
            lk = 1;
      end
      else if (a > (rng ? `PLD_LOSS_LO_CYC : `PLD_LOSS_HI_CYC))
      begin
         cnt = 0;
         lk = 0;
      end
      else
         cnt = 0;
      if (dis != 0)
         lk = 0;
      stat();
   endtask

   initial
   begin
      repeat (60000) @(posedge clk);
      num_errors++;
      end_of_test();
   end

   initial
   begin
      void'($urandom(2));
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      apb(0, CTRL_A, 32'h0);
      chk("ctrl_rst", 32'h0, rd);
      stat();
      apb(0, 12'h100, 32'h0);
      chk("unmapped", 32'h1, {31'h0, er});
      apb(1, STAT_A, 32'h1);
      chk("ro_write", 32'h1, {31'h0, er});
      apb(1, 12'(CTRL_A + 1), 32'h4);
      chk("misalign", 32'h1, {31'h0, er});
      apb(0, CTRL_A, 32'h0);
      chk("misalign_ctrl", 32'h0, rd);
      apb(1, CTRL_A, 32'hFFFFFFFF);
      apb(0, CTRL_A, 32'h0);
      chk("ctrl_bits", 32'hF, rd);
      for (int s = 0; s < 4; s++)
      begin
         cfg(s, 0, 0);
         repeat (need_of(s) + 1) pair(s - 1);
      end
      cfg(0, 0, 0);
      foreach (hy[i]) pair(hy[i]);
      cfg(0, 1, 0);
      foreach (lo[i]) pair(lo[i]);
      cfg(0, 0, 1);
      repeat (6) pair(0);
      for (int k = 0; k < 3; k++)
      begin
         cfg($urandom_range(1), $urandom_range(1), 0);
         repeat (40) pair(int'($urandom_range(20)) - 10);
      end
      end_of_test();
   end
endmodule // testbench

/* File: rtl/pld_params.svh */
// Offsets, field positions, reset values and counts of the lock detector
`ifndef PLD_PARAMS_SVH
`define PLD_PARAMS_SVH

// -----------------------------------------------------------------
// Register indexes (byte address is four times the index)
// -----------------------------------------------------------------
`define PLD_CTRL_IDX 12'h019
`define PLD_STAT_IDX 12'h030
`define PLD_IDX_LSB 2

// -----------------------------------------------------------------
// Control fields and reset value
// -----------------------------------------------------------------
`define PLD_CTRL_W 4
`define PLD_CTRL_RST 4'h0
`define PLD_SEL_LSB 2
`define PLD_RANGE_BIT 1
`define PLD_DIS_BIT 0

// -----------------------------------------------------------------
// Status fields
// -----------------------------------------------------------------
`define PLD_STAT_LOCK_BIT 0
`define PLD_STAT_CNT_LSB 8

// -----------------------------------------------------------------
// Consecutive cycles needed per count select code
// -----------------------------------------------------------------
`define PLD_NEED_00 8'h05
`define PLD_NEED_01 8'h10
`define PLD_NEED_10 8'h40
`define PLD_NEED_11 8'hFF

// -----------------------------------------------------------------
// Window and loss limits in CLK cycles
// -----------------------------------------------------------------
`define PLD_WIN_HI_CYC 4
`define PLD_WIN_LO_CYC 2
`define PLD_LOSS_HI_CYC 8
`define PLD_LOSS_LO_CYC 4

`endif

/* File: rtl/pld_pkg.sv */
// Types shared by the lock detector
package pld_pkg;

   // Control register layout, bit 3 down to bit 0
   typedef struct packed {
      logic [1:0] cnt_sel;
      logic range_low;
      logic det_off;
   } pld_ctrl_s;

   // One finished edge comparison
   typedef struct packed {
      logic valid;
      logic in_win;
      logic loss;
   } pld_eval_s;

   typedef enum logic [1:0] {
      PLD_IDLE,
      PLD_WAIT_FB,
      PLD_WAIT_REF
   } pld_meas_e;

endpackage

/* File: rtl/pld_top.sv */
// Digital lock detector with APB control and status registers
//
// Register access over APB was decided locally.
`include "pld_params.svh"

module pld_top #(
   parameter int DIFF_W = 8,
   parameter int WIN_HI = `PLD_WIN_HI_CYC,
   parameter int WIN_LO = `PLD_WIN_LO_CYC,
   parameter int LOSS_HI = `PLD_LOSS_HI_CYC,
   parameter int LOSS_LO = `PLD_LOSS_LO_CYC
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [11:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   input wire logic REF_IN,
   input wire logic FB_IN,
   output logic LOCK_FLAG
);
   import pld_pkg::*;

   // ---------------------------------------------------------------
   // Parameter checks
   // ---------------------------------------------------------------
   // Difference counter must hold threshold plus one; window must not exceed threshold
   if (DIFF_W < 4 || DIFF_W > 16 || WIN_LO < 1 || WIN_LO > LOSS_LO || WIN_HI > LOSS_HI
      || LOSS_HI >= (2 ** DIFF_W) - 1 || LOSS_LO >= (2 ** DIFF_W) - 1)
   begin : g_bad_params
      $error("lock detector parameters out of range");
   end

   localparam logic [DIFF_W-1:0] WIN_HI_C = DIFF_W'(WIN_HI);
   localparam logic [DIFF_W-1:0] WIN_LO_C = DIFF_W'(WIN_LO);
   localparam logic [DIFF_W-1:0] LOSS_HI_C = DIFF_W'(LOSS_HI);
   localparam logic [DIFF_W-1:0] LOSS_LO_C = DIFF_W'(LOSS_LO);

   // ---------------------------------------------------------------
   // Edge input synchronisers
   // ---------------------------------------------------------------
   logic ref_s1_reg, ref_s2_reg, ref_s3_reg;
   logic fb_s1_reg, fb_s2_reg, fb_s3_reg;
   logic ref_rise, fb_rise;

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ref_s1_reg <= 1'b0;
         ref_s2_reg <= 1'b0;
         ref_s3_reg <= 1'b0;
         fb_s1_reg <= 1'b0;
         fb_s2_reg <= 1'b0;
         fb_s3_reg <= 1'b0;
      end
      else
      begin
         ref_s1_reg <= REF_IN;
         ref_s2_reg <= ref_s1_reg;
         ref_s3_reg <= ref_s2_reg;
         fb_s1_reg <= FB_IN;
         fb_s2_reg <= fb_s1_reg;
         fb_s3_reg <= fb_s2_reg;
      end
   end

   assign ref_rise = ref_s2_reg & ~ref_s3_reg;
   assign fb_rise = fb_s2_reg & ~fb_s3_reg;

   // ---------------------------------------------------------------
   // Control register and window selection
   // ---------------------------------------------------------------
   pld_ctrl_s ctrl_reg, ctrl_next;
   logic [DIFF_W-1:0] win_lim, loss_lim;
   logic [7:0] need;

   assign win_lim = ctrl_reg.range_low ? WIN_LO_C : WIN_HI_C;
   assign loss_lim = ctrl_reg.range_low ? LOSS_LO_C : LOSS_HI_C;

   always_comb
   begin
      unique case (ctrl_reg.cnt_sel)
         2'b00: need = `PLD_NEED_00;
         2'b01: need = `PLD_NEED_01;
         2'b10: need = `PLD_NEED_10;
         2'b11: need = `PLD_NEED_11;
      endcase
   end

   // ---------------------------------------------------------------
   // Edge difference measurement
   // ---------------------------------------------------------------
   pld_meas_e meas_reg, meas_next;
   logic [DIFF_W-1:0] diff_reg, diff_next;
   logic [DIFF_W-1:0] eval_diff;
   logic eval_go;
   pld_eval_s eval;

   always_comb
   begin
      meas_next = meas_reg;
      diff_next = diff_reg;
      eval_go = 1'b0;
      eval_diff = diff_reg + DIFF_W'(1);
      unique case (meas_reg)
         PLD_IDLE:
         begin
            diff_next = '0;
            if (ref_rise && fb_rise)
            begin
               eval_go = 1'b1;
               eval_diff = '0;
            end
            else if (ref_rise)
               meas_next = PLD_WAIT_FB;
            else if (fb_rise)
               meas_next = PLD_WAIT_REF;
         end
         PLD_WAIT_FB, PLD_WAIT_REF:
         begin
            diff_next = diff_reg + DIFF_W'(1);
            if ((meas_reg == PLD_WAIT_FB) ? fb_rise : ref_rise)
            begin
               eval_go = 1'b1;
               meas_next = PLD_IDLE;
            end
            else if (diff_reg >= loss_lim || ref_rise || fb_rise)
            begin
               // Partner edge missing: judged as beyond the loss threshold
               eval_go = 1'b1;
               eval_diff = loss_lim + DIFF_W'(1);
               meas_next = PLD_IDLE;
            end
         end
      endcase
   end

   always_comb
   begin
      eval.valid = eval_go;
      eval.in_win = eval_diff < win_lim;
      eval.loss = eval_diff > loss_lim;
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         meas_reg <= PLD_IDLE;
         diff_reg <= '0;
      end
      else
      begin
         meas_reg <= meas_next;
         diff_reg <= diff_next;
      end
   end

   // ---------------------------------------------------------------
   // Consecutive count and lock flag
   // ---------------------------------------------------------------
   logic [7:0] cnt_reg, cnt_next;
   logic lock_reg, lock_next;

   always_comb
   begin
      cnt_next = cnt_reg;
      lock_next = lock_reg;
      if (ctrl_reg.det_off)
      begin
         cnt_next = '0;
         lock_next = 1'b0;
      end
      else if (eval.valid)
      begin
         if (eval.in_win)
         begin
            if (cnt_reg < need)
               cnt_next = cnt_reg + 8'h01;
            if (cnt_reg + 8'h01 >= need)
               lock_next = 1'b1;
         end
         else
         begin
            cnt_next = '0;
            if (eval.loss)
               lock_next = 1'b0;
         end
      end
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         cnt_reg <= '0;
         lock_reg <= 1'b0;
      end
      else
      begin
         cnt_reg <= cnt_next;
         lock_reg <= lock_next;
      end
   end

   assign LOCK_FLAG = lock_reg;

   // ---------------------------------------------------------------
   // APB slave
   // ---------------------------------------------------------------
   logic [31:0] prdata_reg, prdata_next;
   logic pready_reg, pready_next;
   logic pslverr_reg, pslverr_next;
   logic hit_ctrl, hit_stat, word_ok, access;

   assign word_ok = PADDR[1:0] == 2'b00;
   assign hit_ctrl = word_ok && PADDR[11:2] == 10'(`PLD_CTRL_IDX);
   assign hit_stat = word_ok && PADDR[11:2] == 10'(`PLD_STAT_IDX);
   assign access = PSEL & PENABLE & ~pready_reg;

   always_comb
   begin
      ctrl_next = ctrl_reg;
      prdata_next = prdata_reg;
      pready_next = access;
      pslverr_next = 1'b0;
      if (access)
      begin
         pslverr_next = ~(hit_ctrl | (hit_stat & ~PWRITE));
         prdata_next = '0;
         if (!PWRITE && hit_ctrl)
            prdata_next[`PLD_CTRL_W-1:0] = ctrl_reg;
         if (!PWRITE && hit_stat)
         begin
            prdata_next[`PLD_STAT_LOCK_BIT] = lock_reg;
            prdata_next[`PLD_STAT_CNT_LSB+:8] = cnt_reg;
         end
      end
      if (PSEL && PENABLE && pready_reg && PWRITE && hit_ctrl)
         ctrl_next = pld_ctrl_s'(PWDATA[`PLD_CTRL_W-1:0]);
   end

   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         ctrl_reg <= pld_ctrl_s'(`PLD_CTRL_RST);
         prdata_reg <= '0;
         pready_reg <= 1'b0;
         pslverr_reg <= 1'b0;
      end
      else
      begin
         ctrl_reg <= ctrl_next;
         prdata_reg <= prdata_next;
         pready_reg <= pready_next;
         pslverr_reg <= pslverr_next;
      end
   end

   assign PRDATA = prdata_reg;
   assign PREADY = pready_reg;
   assign PSLVERR = pslverr_reg;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);

   AST_LOCK_NEEDS_COUNT: assert property (
      $rose(lock_reg) |-> $past(eval.valid) && $past(eval.in_win)
         && ($past(cnt_reg) + 8'h01 >= $past(need)))
      else $error("lock flag rose without full count");

   AST_NEED_DECODE: assert property (
      $rose(lock_reg) && $stable(ctrl_reg.cnt_sel) |->
         $past(cnt_reg) == ((ctrl_reg.cnt_sel == 2'b00) ? 8'h04 :
         (ctrl_reg.cnt_sel == 2'b01) ? 8'h0F :
         (ctrl_reg.cnt_sel == 2'b10) ? 8'h3F : 8'hFE))
      else $error("lock flag rose at wrong count");

   AST_IN_WIN_COUNTS: assert property (
      eval.valid && eval.in_win && !ctrl_reg.det_off && cnt_reg < need
         |=> cnt_reg == $past(cnt_reg) + 8'h01)
      else $error("in-window cycle not counted");

   AST_HYSTERESIS: assert property (
      lock_reg && !ctrl_reg.det_off && !(eval.valid && eval.loss) |=> lock_reg)
      else $error("lock flag dropped inside loss threshold");

   AST_RANGE_SELECT: assert property (
      ctrl_reg.range_low && eval.valid |->
         eval.in_win == (eval_diff < WIN_LO_C) && eval.loss == (eval_diff > LOSS_LO_C))
      else $error("low range limits not applied");

   AST_DISABLE: assert property (
      ctrl_reg.det_off |=> !lock_reg && cnt_reg == 8'h00)
      else $error("detector active while disabled");

   AST_RESTART: assert property (
      eval.valid && !eval.in_win |=> cnt_reg == 8'h00 ##1 cnt_reg <= 8'h01)
      else $error("count not restarted after out-of-window cycle");

   AST_APB_ONE_WAIT: assert property (
      PSEL && !PENABLE ##1 PSEL && PENABLE |=> PREADY)
      else $error("APB answer late");

   COV_LOCK: cover property ($rose(lock_reg));
   COV_LOSS: cover property ($fell(lock_reg) && !$past(ctrl_reg.det_off));
   COV_HOLD: cover property (lock_reg && eval.valid && !eval.in_win && !eval.loss);
   COV_LOW_LOCK: cover property (ctrl_reg.range_low && $rose(lock_reg));

endmodule // pld_top
